// *** common/cft_pkg.sv ***
// Constants, offsets and field layout of the charger flag and zone logic
package cft_pkg;
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned ALERT_US     = 128;
   localparam int unsigned ALERT_CYC    = ALERT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TIMER_CYC    = 1_000_000;
   localparam int unsigned WAKE1_CYC    = 5_000;
   localparam int unsigned WAKE2_CYC    = 20_000;
   localparam int unsigned RSTWARN_CYC  = 40_000;

   localparam int          AW           = 3;
   localparam int          DW           = 16;
   localparam int          NFLAG        = 14;

   localparam logic [2:0]  ADR_FLAG     = 3'h0;
   localparam logic [2:0]  ADR_MASK     = 3'h1;
   localparam logic [2:0]  ADR_CTRL     = 3'h2;
   localparam logic [2:0]  ADR_TCC      = 3'h3;
   localparam logic [2:0]  ADR_FAST_CHARGE_CURRENT_CODE     = 3'h4;
   localparam logic [2:0]  ADR_LIVE     = 3'h5;
   localparam logic [2:0]  ADR_TSV      = 3'h6;

   localparam logic [15:0] MASK_RST     = 16'h3FFF;
   localparam logic [15:0] CTRL_RST     = 16'h0000;
   localparam logic [15:0] TCC_RST      = 16'h0000;
   localparam logic [15:0] FAST_CHARGE_CURRENT_CODE_RST     = 16'h000C;
   localparam logic [15:0] UNMAPPED_VAL = 16'hFFFF;

   localparam int          CTRL_TS_LSB  = 0;
   localparam int          CTRL_EXT_BIT = 2;
   localparam int          CTRL_PG_LSB  = 3;
   localparam int          CTRL_GPO_BIT = 5;
   localparam int          CTRL_RAIL_LSB = 6;
   localparam int          TCC_COOL_LSB = 0;
   localparam int          TCC_WARM_LSB = 8;

   localparam int          F_FOLD  = 0;
   localparam int          F_PGC   = 1;
   localparam int          F_OVP   = 2;
   localparam int          F_BOCP  = 3;
   localparam int          F_COLD  = 4;
   localparam int          F_COOL  = 5;
   localparam int          F_WARM  = 6;
   localparam int          F_HOT   = 7;
   localparam int          F_OPEN  = 8;
   localparam int          F_TMR   = 9;
   localparam int          F_ROCP  = 10;
   localparam int          F_WAKE1 = 11;
   localparam int          F_WAKE2 = 12;
   localparam int          F_RWARN = 13;

   typedef enum logic [1:0] {
      TS_FULL    = 2'b00,
      TS_HOTCOLD = 2'b01,
      TS_OFF     = 2'b10,
      TS_RSVD    = 2'b11
   } cft_ts_mode_type;

   typedef enum logic [1:0] {
      PG_SUPPLY  = 2'b00,
      PG_HOST    = 2'b01,
      PG_BUTTON  = 2'b10,
      PG_RSVD    = 2'b11
   } cft_pg_mode_type;
endpackage : cft_pkg

// *** design/cft_flags.sv ***
// Charger fault flags, alert, safety timer and temperature zone control
// Function
// - Foldback flag on rise, reduced current, timer doubled
// - Supply flag both edges, gates charge, rail
// - Overvoltage: flag, pause, timer reset, battery rail
// - Battery overcurrent: flag, no charge, disconnect battery
// - Hot or cold suspends charge and timer
// - Cool zone scales fast charge current
// - Cool current truncated to whole steps
// - Warm zone lowers regulation voltage
// - Thermistor fault gives 128 us alert pulse
// - Flags sticky until host reads them, timer flag also cleared by toggle
// - Zone scheme full, hot/cold or off
// - Timer expiry flags, blocks charge until toggle
// - Regulator overcurrent flag, no charge effect
// - Button hold flags for three times
// - Supply good pin: supply, host or button
// - Thermistor voltage readable with supply or battery
// - Cool flag on rise, timer doubled option
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module cft_flags
   import cft_pkg::*;
#(
   parameter int unsigned TIMER_CYCLES   = TIMER_CYC,
   parameter int unsigned WAKE1_CYCLES   = WAKE1_CYC,
   parameter int unsigned WAKE2_CYCLES   = WAKE2_CYC,
   parameter int unsigned RSTWARN_CYCLES = RSTWARN_CYC
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wdata,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   output logic      [DW-1:0] o_rdata,
   input  wire logic          i_thermal_foldback,
   input  wire logic          i_input_good,
   input  wire logic          i_input_ovp,
   input  wire logic          i_bat_ocp,
   input  wire logic          i_ts_cold,
   input  wire logic          i_ts_cool,
   input  wire logic          i_ts_warm,
   input  wire logic          i_ts_hot,
   input  wire logic          i_ts_open,
   input  wire logic          i_reg_ocp,
   input  wire logic          i_button_input_n,
   input  wire logic          i_charge_allow,
   input  wire logic          i_bat_present,
   input  wire logic [9:0]    i_ts_voltage,
   output logic               o_alert_n,
   output logic               o_irq,
   output logic               o_charge_enable,
   output logic               o_charge_reduced,
   output logic      [7:0]    o_charge_current_code,
   output logic               o_warm_vreg_active,
   output logic      [7:0]    o_warm_vreg_code,
   output logic               o_timer_running,
   output logic               o_rail_from_input,
   output logic               o_rail_from_battery,
   output logic               o_battery_disconnect,
   output logic               o_supply_good_out,
   output logic               o_supply_good_oe
);

   if (WAKE1_CYCLES == 0 || WAKE1_CYCLES >= WAKE2_CYCLES ||
       WAKE2_CYCLES >= RSTWARN_CYCLES || TIMER_CYCLES < 2) begin : g_bad_param
      $error("cft_flags: timing parameters out of order");
   end

   logic [NFLAG-1:0] flag_reg;
   logic [NFLAG-1:0] flag_next;
   logic [NFLAG-1:0] mask_reg;
   logic [DW-1:0]    ctrl_reg;
   logic [DW-1:0]    tcc_reg;
   logic [DW-1:0]    fast_charge_current_code_reg;
   logic [NFLAG-1:0] cond_d_reg;
   logic             good_d_reg;
   logic             allow_d_reg;
   logic [31:0]      tmr_cnt_reg;
   logic [31:0]      tmr_cnt_next;
   logic             tmr_half_reg;
   logic             tmr_fault_reg;
   logic [31:0]      btn_cnt_reg;
   logic [31:0]      btn_cnt_next;
   logic [10:0]      alert_cnt_reg;
   logic [10:0]      alert_cnt_next;
   logic [DW-1:0]    rdata_next;

   // Register decode
   wire              wr_mask  = i_wr && (i_addr == ADR_MASK);
   wire              wr_ctrl  = i_wr && (i_addr == ADR_CTRL);
   wire              wr_tcc   = i_wr && (i_addr == ADR_TCC);
   wire              wr_fast_charge_current_code  = i_wr && (i_addr == ADR_FAST_CHARGE_CURRENT_CODE);
   wire              rd_flag  = i_rd && (i_addr == ADR_FLAG);

   // Configuration fields
   wire cft_ts_mode_type ts_mode = cft_ts_mode_type'(ctrl_reg[CTRL_TS_LSB +: 2]);
   wire cft_pg_mode_type pg_mode = cft_pg_mode_type'(ctrl_reg[CTRL_PG_LSB +: 2]);
   wire              tmr_ext   = ctrl_reg[CTRL_EXT_BIT];
   wire              gpo_val   = ctrl_reg[CTRL_GPO_BIT];
   wire [1:0]        rail_mode = ctrl_reg[CTRL_RAIL_LSB +: 2];
   wire [2:0]        cool_scl  = tcc_reg[TCC_COOL_LSB +: 3];
   wire [7:0]        warm_code = tcc_reg[TCC_WARM_LSB +: 8];
   wire [7:0]        fast_charge_current_code      = fast_charge_current_code_reg[7:0];

   // Zone response per scheme
   wire              ts_susp  = (ts_mode != TS_OFF) && (i_ts_hot || i_ts_cold);
   wire              cool_act = (ts_mode == TS_FULL) && i_ts_cool;
   wire              warm_act = (ts_mode == TS_FULL) && i_ts_warm;

   // Cool current scaled in eighths, truncated to whole steps
   wire [3:0]        cool_frac = 4'h8 - {1'b0, cool_scl};
   wire [11:0]       cool_prod = {4'h0, fast_charge_current_code} * {8'h00, cool_frac};
   wire [7:0]        cur_code  = cool_act ? cool_prod[10:3] : fast_charge_current_code;

   // Supply or charge-allow toggle
   wire              toggle = (i_input_good ^ good_d_reg) || (i_charge_allow ^ allow_d_reg);

   // Charge gating
   wire              chg_en = i_charge_allow && i_input_good && !i_input_ovp
                              && !i_bat_ocp && !ts_susp && !i_ts_open
                              && !tmr_fault_reg;

   // Safety timer: reset without good supply, on overvoltage or toggle
   wire              tmr_clr  = !i_input_good || i_input_ovp || toggle;
   wire              tmr_dbl  = tmr_ext && (cool_act || i_thermal_foldback);
   wire              tmr_tick = !tmr_dbl || tmr_half_reg;
   wire              tmr_run  = chg_en;
   wire              expire   = tmr_run && tmr_tick && !tmr_clr
                                && (tmr_cnt_reg == 32'(TIMER_CYCLES - 1));

   always_comb begin
      tmr_cnt_next = tmr_cnt_reg;
      if (tmr_clr) begin
         tmr_cnt_next = 32'h0000_0000;
      end else if (expire) begin
         tmr_cnt_next = 32'h0000_0000;
      end else if (tmr_run && tmr_tick) begin
         tmr_cnt_next = tmr_cnt_reg + 32'h0000_0001;
      end
   end

   // Button hold counter saturates at the warning time
   always_comb begin
      btn_cnt_next = btn_cnt_reg;
      if (i_button_input_n) begin
         btn_cnt_next = 32'h0000_0000;
      end else if (btn_cnt_reg != 32'(RSTWARN_CYCLES)) begin
         btn_cnt_next = btn_cnt_reg + 32'h0000_0001;
      end
   end

   wire              wake1 = btn_cnt_reg >= 32'(WAKE1_CYCLES);
   wire              wake2 = btn_cnt_reg >= 32'(WAKE2_CYCLES);
   wire              rwarn = btn_cnt_reg >= 32'(RSTWARN_CYCLES);

   // Flag conditions and events
   wire [NFLAG-1:0]  cond = {rwarn, wake2, wake1, i_reg_ocp, tmr_fault_reg, i_ts_open,
                             i_ts_hot, i_ts_warm, i_ts_cool, i_ts_cold, i_bat_ocp,
                             i_input_ovp, i_input_good, i_thermal_foldback};
   wire [NFLAG-1:0]  rise = cond & ~cond_d_reg;
   wire [NFLAG-1:0]  ev   = {rise[NFLAG-1:F_PGC+1],
                             cond[F_PGC] ^ cond_d_reg[F_PGC],
                             rise[F_FOLD]};
   wire [NFLAG-1:0]  tmr_clr_bit = toggle ? (NFLAG'(1) << F_TMR) : '0;
   wire [NFLAG-1:0]  clr  = (rd_flag ? '1 : '0) | tmr_clr_bit;
   wire [NFLAG-1:0]  ts_bits = cond & (NFLAG'(5'h1F) << F_COLD) & ~(NFLAG'(1) << F_TMR);

   always_comb begin
      flag_next = (flag_reg & ~clr) | ev;
   end

   // Alert pulse
   wire              alert_go = |(ev & mask_reg);
   always_comb begin
      alert_cnt_next = alert_cnt_reg;
      if (alert_go) begin
         alert_cnt_next = 11'(ALERT_CYC);
      end else if (alert_cnt_reg != 11'h000) begin
         alert_cnt_next = alert_cnt_reg - 11'h001;
      end
   end

   // Read mux
   wire [9:0]        tsv = (i_input_good || i_bat_present) ? i_ts_voltage : 10'h000;
   always_comb begin
      rdata_next = 16'h0000;
      if (i_rd) begin
         unique case (i_addr)
            ADR_FLAG: rdata_next = {2'h0, flag_reg};
            ADR_MASK: rdata_next = {2'h0, mask_reg};
            ADR_CTRL: rdata_next = ctrl_reg;
            ADR_TCC:  rdata_next = tcc_reg;
            ADR_FAST_CHARGE_CURRENT_CODE: rdata_next = fast_charge_current_code_reg;
            ADR_LIVE: rdata_next = {2'h0, cond};
            ADR_TSV:  rdata_next = {6'h00, tsv};
            default:  rdata_next = UNMAPPED_VAL;
         endcase
      end
   end

   // Pin and rail decisions
   wire              rail_in = i_input_good && (rail_mode == 2'b00) && !i_input_ovp;
   wire              rail_bat = !rail_in && !i_bat_ocp;
   logic             pg_drive;
   always_comb begin
      unique case (pg_mode)
         PG_HOST:   pg_drive = !gpo_val;
         PG_BUTTON: pg_drive = !i_button_input_n;
         default:   pg_drive = i_input_good;
      endcase
   end

   // Software registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mask_reg <= MASK_RST[NFLAG-1:0];
         ctrl_reg <= CTRL_RST;
         tcc_reg  <= TCC_RST;
         fast_charge_current_code_reg <= FAST_CHARGE_CURRENT_CODE_RST;
      end else begin
         if (wr_mask) mask_reg <= i_wdata[NFLAG-1:0];
         if (wr_ctrl) ctrl_reg <= i_wdata;
         if (wr_tcc)  tcc_reg  <= i_wdata;
         if (wr_fast_charge_current_code) fast_charge_current_code_reg <= i_wdata;
      end
   end

   // Flags, edges and timers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_reg      <= '0;
         cond_d_reg    <= '0;
         good_d_reg    <= 1'b0;
         allow_d_reg   <= 1'b0;
         tmr_cnt_reg   <= 32'h0000_0000;
         tmr_half_reg  <= 1'b0;
         tmr_fault_reg <= 1'b0;
         btn_cnt_reg   <= 32'h0000_0000;
         alert_cnt_reg <= 11'h000;
      end else begin
         flag_reg      <= flag_next;
         cond_d_reg    <= cond;
         good_d_reg    <= i_input_good;
         allow_d_reg   <= i_charge_allow;
         tmr_cnt_reg   <= tmr_cnt_next;
         tmr_half_reg  <= !tmr_half_reg;
         tmr_fault_reg <= expire || (tmr_fault_reg && !toggle);
         btn_cnt_reg   <= btn_cnt_next;
         alert_cnt_reg <= alert_cnt_next;
      end
   end

   // Registered outputs
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata               <= 16'h0000;
         o_charge_enable       <= 1'b0;
         o_charge_reduced      <= 1'b0;
         o_charge_current_code <= 8'h00;
         o_warm_vreg_active    <= 1'b0;
         o_warm_vreg_code      <= 8'h00;
         o_timer_running       <= 1'b0;
         o_rail_from_input     <= 1'b0;
         o_rail_from_battery   <= 1'b0;
         o_battery_disconnect  <= 1'b0;
         o_supply_good_oe      <= 1'b0;
      end else begin
         o_rdata               <= rdata_next;
         o_charge_enable       <= chg_en;
         o_charge_reduced      <= cool_act || i_thermal_foldback;
         o_charge_current_code <= cur_code;
         o_warm_vreg_active    <= warm_act;
         o_warm_vreg_code      <= warm_code;
         o_timer_running       <= tmr_run;
         o_rail_from_input     <= rail_in;
         o_rail_from_battery   <= rail_bat;
         o_battery_disconnect  <= i_bat_ocp;
         o_supply_good_oe      <= pg_drive;
      end
   end

   assign o_supply_good_out = 1'b0;
   assign o_alert_n         = (alert_cnt_reg == 11'h000);
   assign o_irq             = |(flag_reg & mask_reg);

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence expire_s;
      expire ##1 !toggle;
   endsequence
   sequence blocked_s;
      !o_charge_enable && !o_timer_running;
   endsequence

   alert_start_a: assert property (
      alert_go |=> (alert_cnt_reg == 11'(ALERT_CYC)) ##1 !o_alert_n)
      else $error("alert pulse not started");
   ts_alert_a: assert property (
      |(ev & ts_bits & mask_reg) |=> !o_alert_n [*8])
      else $error("thermistor fault gave no alert");
   flag_sticky_a: assert property (
      flag_reg[F_OVP] && !rd_flag |=> flag_reg[F_OVP])
      else $error("flag dropped without read");
   read_clear_a: assert property (
      rd_flag && (ev == '0) |=> (flag_reg == '0))
      else $error("flag read did not clear");
   set_wins_a: assert property (
      rd_flag && ev[F_HOT] |=> flag_reg[F_HOT])
      else $error("event lost during clear");
   rise_only_a: assert property (
      i_input_ovp && $past(i_input_ovp) && !$past(i_rst) |-> !ev[F_OVP])
      else $error("held condition raised event");
   pg_edges_a: assert property (
      $changed(i_input_good) && !$past(i_rst) |-> ev[F_PGC])
      else $error("supply change not flagged");
   charge_off_a: assert property (
      !i_input_good || i_input_ovp || i_bat_ocp |=> !o_charge_enable)
      else $error("charging not stopped");
   ts_susp_a: assert property (
      (ts_mode != TS_OFF) && i_ts_hot |=> blocked_s)
      else $error("hot zone did not suspend");
   tmr_block_a: assert property (
      expire_s |=> blocked_s ##0 flag_reg[F_TMR])
      else $error("timer expiry not blocking");
   rail_src_a: assert property (
      1'b1 |=> o_rail_from_input ==
               $past(i_input_good && rail_mode == 2'b00 && !i_input_ovp))
      else $error("rail source wrong");
   cool_cur_a: assert property (
      cool_act && (cool_scl == 3'h7) |=> o_charge_current_code == ($past(fast_charge_current_code) >> 3))
      else $error("cool current not truncated");
   rdata_one_a: assert property (
      !i_rd |=> (o_rdata == 16'h0000))
      else $error("read data outside read cycle");
   fold_flag_a: assert property (
      $rose(i_thermal_foldback) |=> flag_reg[F_FOLD])
      else $error("foldback flag not set");
   fold_reduce_a: assert property (
      i_thermal_foldback |=> o_charge_reduced)
      else $error("foldback did not reduce current");
   tmr_clear_a: assert property (
      !i_input_good || i_input_ovp |=> (tmr_cnt_reg == 32'h0000_0000))
      else $error("safety timer not reset");
   bat_disc_a: assert property (
      i_bat_ocp |=> o_battery_disconnect && !o_rail_from_battery)
      else $error("battery not disconnected");
   ovp_rail_a: assert property (
      i_input_ovp && !i_bat_ocp |=> o_rail_from_battery && !o_rail_from_input)
      else $error("rail not moved to battery");
   ts_pause_a: assert property (
      ts_susp && !tmr_clr |=> $stable(tmr_cnt_reg))
      else $error("timer ran in hot or cold zone");
   warm_vreg_a: assert property (
      (ts_mode == TS_FULL) && i_ts_warm |=> o_warm_vreg_active)
      else $error("warm zone voltage not lowered");
   zone_off_a: assert property (
      (ts_mode != TS_FULL) |=> !o_warm_vreg_active && (o_charge_current_code == $past(fast_charge_current_code)))
      else $error("zone response outside full scheme");
   tmr_flag_clr_a: assert property (
      toggle && !ev[F_TMR] |=> !flag_reg[F_TMR])
      else $error("timer flag kept after toggle");
   rocp_flag_a: assert property (
      $rose(i_reg_ocp) |=> flag_reg[F_ROCP])
      else $error("regulator overcurrent not flagged");
   btn_warn_a: assert property (
      $rose(rwarn) |=> flag_reg[F_RWARN])
      else $error("reset warning not flagged");
   pg_button_a: assert property (
      (pg_mode == PG_BUTTON) |=> (o_supply_good_oe == !$past(i_button_input_n)))
      else $error("supply good pin not following button");

endmodule : cft_flags

// *** dv/cft_host_model.sv ***
// Host side register bus master for the charger flag logic
`timescale 1ns/100ps
module cft_host_model
   import cft_pkg::*;
(
   input  wire logic          i_sys_clk,
   input  wire logic [DW-1:0] i_rdata,
   output logic      [AW-1:0] o_addr,
   output logic      [DW-1:0] o_wdata,
   output logic               o_wr,
   output logic               o_rd
);
   initial begin
      o_addr  = '0;
      o_wdata = '0;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // Single cycle write, address and data scrambled after release
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] dat);
      @(posedge i_sys_clk);
      o_addr  <= a;
      o_wdata <= dat;
      o_wr    <= 1'b1;
      @(posedge i_sys_clk);
      o_wr    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~dat;
   endtask : wr

   // Single cycle read, data taken in the following cycle
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] dat);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_sys_clk);
      o_rd   <= 1'b0;
      o_addr <= ~a;
      #1 dat = i_rdata;
   endtask : rd
endmodule : cft_host_model

// *** dv/cft_flags_tb.sv ***
// Self-checking bench for the charger flag and zone logic
`timescale 1ns/100ps
module cft_flags_tb;
   import cft_pkg::*;
   logic          i_sys_clk = 1'b0;
   logic          i_rst     = 1'b1;
   wire  [AW-1:0] i_addr;
   wire  [DW-1:0] i_wdata;
   wire           i_wr;
   wire           i_rd;
   logic [DW-1:0] o_rdata;
   logic [13:0]   cond      = '0;
   logic          btn_n     = 1'b1;
   logic          allow     = 1'b0;
   logic          bat       = 1'b0;
   logic [9:0]    volt      = '0;
   logic          o_alert_n, o_irq, o_charge_enable, o_charge_reduced, o_warm_vreg_active;
   logic [7:0]    o_charge_current_code, o_warm_vreg_code;
   logic          o_timer_running, o_rail_from_input, o_rail_from_battery;
   logic          o_battery_disconnect, o_supply_good_out, o_supply_good_oe;
   logic [DW-1:0] d;
   logic [7:0]    fast_charge_current_code;
   logic [2:0]    sc;
   int            n_mismatch  = 0;
   int            checks_done = 0;
   int            n;
   int            bl[5] = '{F_OVP, F_BOCP, F_HOT, F_COLD, F_OPEN};

   always #50 i_sys_clk = ~i_sys_clk;

   cft_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

   cft_flags #(.TIMER_CYCLES(200), .WAKE1_CYCLES(4), .WAKE2_CYCLES(8),
      .RSTWARN_CYCLES(12)) DUT (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_thermal_foldback(cond[F_FOLD]),
      .i_input_good(cond[F_PGC]), .i_input_ovp(cond[F_OVP]), .i_bat_ocp(cond[F_BOCP]),
      .i_ts_cold(cond[F_COLD]), .i_ts_cool(cond[F_COOL]), .i_ts_warm(cond[F_WARM]),
      .i_ts_hot(cond[F_HOT]), .i_ts_open(cond[F_OPEN]), .i_reg_ocp(cond[F_ROCP]),
      .i_button_input_n(btn_n), .i_charge_allow(allow), .i_bat_present(bat),
      .i_ts_voltage(volt), .o_alert_n(o_alert_n), .o_irq(o_irq),
      .o_charge_enable(o_charge_enable), .o_charge_reduced(o_charge_reduced),
      .o_charge_current_code(o_charge_current_code), .o_warm_vreg_active(o_warm_vreg_active),
      .o_warm_vreg_code(o_warm_vreg_code), .o_timer_running(o_timer_running),
      .o_rail_from_input(o_rail_from_input), .o_rail_from_battery(o_rail_from_battery),
      .o_battery_disconnect(o_battery_disconnect), .o_supply_good_out(o_supply_good_out),
      .o_supply_good_oe(o_supply_good_oe));

   // Cool zone current, scaled by eighths and truncated
   function automatic logic [7:0] cool_cur(input logic [7:0] c, input logic [2:0] s);
      return 8'((16'(c) * (16'h0008 - 16'(s))) >> 3);
   endfunction : cool_cur

   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic rdm(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
      host.rd(a, d);
      check(d & m, e);
   endtask : rdm

   task automatic tick(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask : tick

   task automatic setc(input int b, input logic v);
      @(posedge i_sys_clk);
      cond[b] <= v;
   endtask : setc

   task automatic toggle();
      @(posedge i_sys_clk);
      allow <= 1'b0;
      @(posedge i_sys_clk);
      allow <= 1'b1;
   endtask : toggle

   task automatic plen(output int k);
      int w;
      w = 0;
      k = 0;
      while (o_alert_n !== 1'b0 && w < 5) begin
         tick(1);
         w++;
      end
      while (o_alert_n === 1'b0 && k < 3000) begin
         tick(1);
         k++;
      end
   endtask : plen

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   initial begin
      repeat (12000) @(posedge i_sys_clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      void'($urandom(31));
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rdm(ADR_MASK, 16'hFFFF, MASK_RST);
      rdm(ADR_FAST_CHARGE_CURRENT_CODE, 16'hFFFF, FAST_CHARGE_CURRENT_CODE_RST);
      rdm(3'h7, 16'hFFFF, UNMAPPED_VAL);
      host.wr(ADR_LIVE, 16'h00FF);
      rdm(ADR_LIVE, 16'hFFFF, 16'h0000);
      done("registers");
      host.wr(ADR_CTRL, DW'(TS_OFF));
      setc(F_OPEN, 1'b1);
      plen(n);
      check(DW'(n), DW'(ALERT_CYC));
      tick(20);
      check(DW'(o_alert_n), 16'h0001);
      setc(F_OPEN, 1'b0);
      tick(3);
      rdm(ADR_FLAG, 16'hFFFF, 16'h0001 << F_OPEN);
      rdm(ADR_FLAG, 16'hFFFF, 16'h0000);
      done("alert");
      host.wr(ADR_MASK, 16'h0000);
      setc(F_PGC, 1'b1);
      tick(3);
      check(DW'({o_irq, o_alert_n}), 16'h0001);
      rdm(ADR_FLAG, 16'hFFFF, 16'h0001 << F_PGC);
      host.wr(ADR_MASK, MASK_RST);
      setc(F_PGC, 1'b0);
      tick(3);
      check(DW'(o_irq), 16'h0001);
      rdm(ADR_FLAG, 16'hFFFF, 16'h0001 << F_PGC);
      check(DW'(o_irq), 16'h0000);
      done("supply change");
      setc(F_PGC, 1'b1);
      toggle();
      tick(3);
      check(DW'({o_charge_enable, o_rail_from_input}), 16'h0003);
      host.wr(ADR_CTRL, 16'h0001 << CTRL_RAIL_LSB);
      tick(2);
      check(DW'(o_rail_from_input), 16'h0000);
      host.wr(ADR_CTRL, DW'(TS_FULL));
      for (int i = 0; i < 5; i++) begin
         toggle();
         setc(bl[i], 1'b1);
         tick(3);
         check(DW'(o_charge_enable), 16'h0000);
         if (i == 0)
            check(DW'({o_rail_from_input, o_rail_from_battery}), 16'h0001);
         if (i == 1)
            check(DW'(o_battery_disconnect), 16'h0001);
         setc(bl[i], 1'b0);
      end
      host.wr(ADR_CTRL, DW'(TS_OFF));
      toggle();
      setc(F_HOT, 1'b1);
      tick(3);
      check(DW'(o_charge_enable), 16'h0001);
      setc(F_HOT, 1'b0);
      done("charge gating");
      host.wr(ADR_CTRL, DW'(TS_HOTCOLD));
      toggle();
      setc(F_COOL, 1'b1);
      tick(3);
      check(DW'(o_charge_current_code), FAST_CHARGE_CURRENT_CODE_RST);
      host.wr(ADR_CTRL, DW'(TS_FULL));
      fast_charge_current_code = 8'h0C;
      sc = 3'h7;
      for (int i = 0; i < 8; i++) begin
         host.wr(ADR_FAST_CHARGE_CURRENT_CODE, DW'(fast_charge_current_code));
         host.wr(ADR_TCC, DW'(sc));
         tick(2);
         check(DW'(o_charge_current_code), DW'(cool_cur(fast_charge_current_code, sc)));
         check(DW'(o_charge_reduced), 16'h0001);
         fast_charge_current_code = 8'($urandom);
         sc = 3'($urandom);
      end
      rdm(ADR_FLAG, 16'h0001 << F_COOL, 16'h0001 << F_COOL);
      setc(F_COOL, 1'b0);
      host.wr(ADR_TCC, 16'hA500);
      setc(F_WARM, 1'b1);
      tick(3);
      check(DW'({o_warm_vreg_active, o_charge_enable, o_warm_vreg_code}), 16'h03A5);
      setc(F_WARM, 1'b0);
      done("zones");
      toggle();
      tick(3);
      n = 0;
      while (o_charge_enable !== 1'b0 && n < 400) begin
         tick(1);
         n++;
      end
      check(DW'(n >= 190 && n <= 210), 16'h0001);
      rdm(ADR_FLAG, 16'h0001 << F_TMR, 16'h0001 << F_TMR);
      tick(5);
      check(DW'({o_charge_enable, o_timer_running}), 16'h0000);
      toggle();
      tick(3);
      check(DW'({o_charge_enable, o_timer_running}), 16'h0003);
      host.wr(ADR_CTRL, 16'h0001 << CTRL_EXT_BIT);
      setc(F_FOLD, 1'b1);
      toggle();
      tick(3);
      check(DW'({o_charge_reduced, o_charge_enable}), 16'h0003);
      n = 0;
      while (o_charge_enable !== 1'b0 && n < 800) begin
         tick(1);
         n++;
      end
      check(DW'(n >= 390 && n <= 410), 16'h0001);
      rdm(ADR_FLAG, 16'h0001 << F_FOLD, 16'h0001 << F_FOLD);
      setc(F_FOLD, 1'b0);
      setc(F_ROCP, 1'b1);
      toggle();
      tick(3);
      check(DW'(o_charge_enable), 16'h0001);
      rdm(ADR_FLAG, 16'h0001 << F_ROCP, 16'h0001 << F_ROCP);
      setc(F_ROCP, 1'b0);
      done("safety timer");
      check(DW'({o_supply_good_oe, o_supply_good_out}), 16'h0002);
      host.wr(ADR_CTRL, (DW'(PG_HOST) << CTRL_PG_LSB) | (16'h0001 << CTRL_GPO_BIT));
      tick(2);
      check(DW'(o_supply_good_oe), 16'h0000);
      host.wr(ADR_CTRL, DW'(PG_BUTTON) << CTRL_PG_LSB);
      @(posedge i_sys_clk);
      btn_n <= 1'b0;
      tick(16);
      check(DW'(o_supply_good_oe), 16'h0001);
      rdm(ADR_FLAG, 16'h3800, 16'h3800);
      @(posedge i_sys_clk);
      btn_n <= 1'b1;
      volt <= 10'($urandom) | 10'h001;
      cond[F_PGC] <= 1'b0;
      tick(3);
      rdm(ADR_TSV, 16'hFFFF, 16'h0000);
      @(posedge i_sys_clk);
      bat <= 1'b1;
      tick(3);
      rdm(ADR_TSV, 16'hFFFF, DW'(volt));
      done("pin and voltage");
      conclude();
   end
endmodule : cft_flags_tb
